// ===== verification/reg_host_model.sv
// Purpose: Host side of the register bus, issuing single-byte writes and reads.
// Assumes: Strobes are one-cycle pulses taken on the rising mclk edge.
// Notes: Released address lines show the inverse of the last address; data lines are inverted only after a write.
`timescale 1ns/1ps
module reg_host_model
  import bl_cfg_pkg::*;
(
  input wire logic mclk,
  output bl_cfg_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  end

  // One write strobe, held up to the taking edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #2;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #2;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read strobe, data taken after the answering edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #2;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: reg_req.wdata};
    @(posedge mclk);
    #2;
    d = reg_rdata;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: reg_req.wdata};
  endtask
endmodule

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the sensor resistor and brightness registers.
// Assumes: 40 MHz mclk, inputs driven 2 ns after the rising edge.
// Notes: Level figures are parts per 100000 of full scale.
`timescale 1ns/1ps
module tb_top;
  import bl_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [2:0] full_scale_sel = 3'h0;
  logic profile_linear = 1'b0;
  logic [14:0] sel_one, sel_two;
  logic [15:0] ohm_one, ohm_two;
  logic [3:0] bits_one, bits_two;
  logic [6:0] brightness_code;
  logic [2:0] fs_out;
  logic prof_out;
  logic [16:0] led_level;
  logic led_level_valid;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] rd;
  // Expected resistance per code, open at zero
  logic [15:0] ohm_exp [16] = '{16'h0000, 16'h34DB, 16'h2333, 16'h1524, 16'h08DF, 16'h079A,
    16'h0717, 16'h0640, 16'h0472, 16'h041A, 16'h03F3, 16'h03AD, 16'h02F7, 16'h02CF, 16'h02BC, 16'h029B};

  // Clock, 25 ns period
  always #12.5 mclk = ~mclk;

  reg_host_model host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  backlight_brightness_als_config uut (.mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .full_scale_sel(full_scale_sel), .profile_linear(profile_linear),
    .light_sensor_input_one_sel(sel_one), .light_sensor_input_two_sel(sel_two),
    .light_sensor_input_one_ohm(ohm_one), .light_sensor_input_two_ohm(ohm_two),
    .sensor_one_res_bit3(bits_one[3]), .sensor_one_res_bit2(bits_one[2]),
    .sensor_one_res_bit1(bits_one[1]), .sensor_one_res_bit0(bits_one[0]),
    .sensor_two_res_bit3(bits_two[3]), .sensor_two_res_bit2(bits_two[2]),
    .sensor_two_res_bit1(bits_two[1]), .sensor_two_res_bit0(bits_two[0]),
    .brightness_code(brightness_code), .full_scale_led_current(fs_out), .led_profile_linear(prof_out),
    .led_level(led_level), .led_level_valid(led_level_valid));

  // Compare and count
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait for a finished conversion
  task automatic wait_valid();
    int n;
    n = 0;
    while (led_level_valid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #2;
      n++;
    end
    // A conversion that never finishes counts as a mismatch
    if (led_level_valid !== 1'b1) begin
      err_total++;
      $display("Error level valid expected 1 seen %b", led_level_valid);
    end
  endtask

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Values straight after reset
  task automatic reset_values();
    wait_valid();
    chk("level after reset", 17'h1_86A0, led_level);
    host.read_reg(8'h41, rd);
    chk("sensor select reset", 17'h0_0000, {9'h000, rd});
    host.read_reg(8'hA0, rd);
    chk("brightness reset", 17'h0_007F, {9'h000, rd});
  endtask

  // All sixteen codes on both inputs at once
  task automatic sensor_table();
    logic [3:0] a;
    logic [3:0] b;
    for (int c = 0; c < 16; c++) begin
      a = c[3:0];
      b = 4'hF - a;
      host.write_reg(8'h41, {b, a});
      chk("one ohm", {1'b0, ohm_exp[a]}, {1'b0, ohm_one});
      chk("two ohm", {1'b0, ohm_exp[b]}, {1'b0, ohm_two});
      chk("one switch", (a == 4'h0) ? 17'h0_0000 : 17'h0_0001 << (a - 4'h1), {2'h0, sel_one});
      chk("two switch", (b == 4'h0) ? 17'h0_0000 : 17'h0_0001 << (b - 4'h1), {2'h0, sel_two});
      chk("select bits", {9'h000, b, a}, {9'h000, bits_two, bits_one});
      host.read_reg(8'h41, rd);
      chk("select readback", {9'h000, b, a}, {9'h000, rd});
    end
  endtask

  // Codes in both profiles, top bit always set in the write
  task automatic brightness_levels();
    logic [6:0] codes [4] = '{7'h00, 7'h01, 7'h40, 7'h7F};
    for (int p = 0; p < 2; p++) begin
      profile_linear = p[0];
      repeat (2) @(posedge mclk);
      #2;
      for (int i = 0; i < 4; i++) begin
        host.write_reg(8'hA0, {1'b1, codes[i]});
        wait_valid();
        chk("profile out", {16'h0000, p[0]}, {16'h0000, prof_out});
        if (codes[i] == 7'h00) chk("level off", 17'h0_0000, led_level);
        if (codes[i] == 7'h7F) chk("level full", 17'h1_86A0, led_level);
        if (codes[i] == 7'h01) chk("level one", p[0] ? 17'h0_0313 : 17'h0_0050, led_level);
        if (codes[i] == 7'h40 && p[0]) chk("level mid", 17'h0_C4D9, led_level);
        host.read_reg(8'hA0, rd);
        chk("brightness readback", {10'h000, codes[i]}, {9'h000, rd});
        chk("brightness code", {10'h000, codes[i]}, {10'h000, brightness_code});
      end
    end
    for (int f = 0; f < 8; f++) begin
      full_scale_sel = f[2:0];
      repeat (2) @(posedge mclk);
      #2;
      chk("full scale", {14'h0000, f[2:0]}, {14'h0000, fs_out});
    end
  endtask

  // Unmapped place: write ignored, read zero
  task automatic unmapped_access();
    host.write_reg(8'h41, 8'h5A);
    host.write_reg(8'h42, 8'hFF);
    host.read_reg(8'h42, rd);
    chk("unmapped read", 17'h0_0000, {9'h000, rd});
    host.read_reg(8'h41, rd);
    chk("select kept", 17'h0_005A, {9'h000, rd});
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    #2;
    rst = 1'b0;
    reset_values();
    sensor_table();
    brightness_levels();
    unmapped_access();
    give_verdict();
  end
endmodule

// ===== verilog/backlight_brightness_als_config.sv
// Purpose: Sensor resistor select and LED brightness registers with level conversion.
// Assumes: Host front end delivers one-cycle write and read strobes with address and data.
// Notes: Full-scale select and profile bit live in another register bank and come in as pins.
// Contract
// - Resistor select: low nibble one, high two
// - Low nibble zero leaves sensor one open
// - High nibble zero leaves sensor two open
// - Fifteen codes, resistance falls with code
// - Brightness register: seven-bit code, 127 levels
// - Level is fraction of selected full scale
// - Profile bit zero exponential, one linear
// - Code one: 0.08% exponential, 0.79% linear
`timescale 1ns/1ps
module backlight_brightness_als_config
  import bl_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input bl_cfg_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] full_scale_sel,
  input wire logic profile_linear,
  output logic [14:0] light_sensor_input_one_sel,
  output logic [14:0] light_sensor_input_two_sel,
  output logic [15:0] light_sensor_input_one_ohm,
  output logic [15:0] light_sensor_input_two_ohm,
  output logic sensor_one_res_bit3,
  output logic sensor_one_res_bit2,
  output logic sensor_one_res_bit1,
  output logic sensor_one_res_bit0,
  output logic sensor_two_res_bit3,
  output logic sensor_two_res_bit2,
  output logic sensor_two_res_bit1,
  output logic sensor_two_res_bit0,
  output logic [6:0] brightness_code,
  output logic [2:0] full_scale_led_current,
  output logic led_profile_linear,
  output logic [16:0] led_level,
  output logic led_level_valid
);

  import bl_cfg_pkg::*;

  bank_state_s s_q, s_d; // All bank state
  logic wr_sel; // Write to resistor select
  logic wr_brt; // Write to brightness
  logic conv_start; // Recompute level
  logic [7:0] sel_next; // Resistor select after this cycle's write
  logic [3:0] nib [2]; // Next nibbles per sensor
  logic [14:0] oh_d [2]; // Next one-hot switch pattern
  logic [15:0] ohm_d [2]; // Next resistance figure

  // One-hot switch for a code; zero opens every switch
  function automatic logic [14:0] res_onehot(input logic [3:0] c);
    logic [14:0] r;
    r = '0;
    if (c != 4'h0) begin
      r = 15'h0001 << (c - 4'h1);
    end
    return r;
  endfunction

  // Address decode
  assign wr_sel = reg_req.wr && reg_req.addr == SENSOR_RES_SEL_ADDR;
  assign wr_brt = reg_req.wr && reg_req.addr == LED_BRIGHTNESS_ADDR;

  // Next select value, so the decode tracks the register without a loop through s_d
  assign sel_next = wr_sel ? reg_req.wdata : s_q.sel;
  assign nib[0] = sel_next[SENSOR_ONE_LSB +: RES_FIELD_W];
  assign nib[1] = sel_next[SENSOR_TWO_LSB +: RES_FIELD_W];

  // Same decode for both sensor inputs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sensor
      assign oh_d[gi] = res_onehot(nib[gi]);
      assign ohm_d[gi] = RES_OHM_TABLE[nib[gi]];
    end
  endgenerate

  // Register bank next state
  always_comb begin
    s_d = s_q;
    s_d.init = 1'b0;
    // Writes
    if (wr_sel) begin
      s_d.sel = reg_req.wdata;
    end
    if (wr_brt) begin
      s_d.led_brightness_code = reg_req.wdata[BRT_CODE_W-1:0];
    end
    // Reads, unmapped addresses answer zero
    if (reg_req.rd) begin
      case (reg_req.addr)
        SENSOR_RES_SEL_ADDR: begin
          s_d.rdata = s_q.sel;
        end
        LED_BRIGHTNESS_ADDR: begin
          s_d.rdata = {1'b0, s_q.led_brightness_code};
        end
        default: begin
          s_d.rdata = UNMAPPED_RDATA;
        end
      endcase
    end
    // Mirror the general configuration fields
    s_d.fs = full_scale_sel;
    s_d.lin = profile_linear;
    // Decoded switch pattern for the next select value
    s_d.oh_one = oh_d[0];
    s_d.oh_two = oh_d[1];
    s_d.ohm_one = ohm_d[0];
    s_d.ohm_two = ohm_d[1];
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{sel: SENSOR_RES_SEL_RST, led_brightness_code: BRIGHTNESS_RST, rdata: 8'h00, oh_one: 15'h0000,
               oh_two: 15'h0000, ohm_one: 16'h0000, ohm_two: 16'h0000, fs: 3'h0, lin: 1'b0,
               init: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Recompute after reset, a brightness write or a profile change
  assign conv_start = s_q.init || wr_brt || (s_q.lin != profile_linear);

  // Code to level converter
  brightness_level_conv u_conv (
    .mclk(mclk),
    .rst(rst),
    .start(conv_start),
    .code(s_d.led_brightness_code),
    .linear(profile_linear),
    .level(led_level),
    .level_valid(led_level_valid)
  );

  // Outputs from the state register
  assign reg_rdata = s_q.rdata;
  assign light_sensor_input_one_sel = s_q.oh_one;
  assign light_sensor_input_two_sel = s_q.oh_two;
  assign light_sensor_input_one_ohm = s_q.ohm_one;
  assign light_sensor_input_two_ohm = s_q.ohm_two;
  assign {sensor_one_res_bit3, sensor_one_res_bit2, sensor_one_res_bit1, sensor_one_res_bit0} =
    s_q.sel[SENSOR_ONE_LSB +: RES_FIELD_W];
  assign {sensor_two_res_bit3, sensor_two_res_bit2, sensor_two_res_bit1, sensor_two_res_bit0} =
    s_q.sel[SENSOR_TWO_LSB +: RES_FIELD_W];
  assign brightness_code = s_q.led_brightness_code;
  assign full_scale_led_current = s_q.fs;
  assign led_profile_linear = s_q.lin;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sel_write;
    reg_req.wr && reg_req.addr == SENSOR_RES_SEL_ADDR;
  endsequence

  sequence brt_write;
    reg_req.wr && reg_req.addr == LED_BRIGHTNESS_ADDR;
  endsequence

  AST_SEL_WRITE: assert property (sel_write |=>
      {sensor_two_res_bit3, sensor_two_res_bit2, sensor_two_res_bit1, sensor_two_res_bit0,
       sensor_one_res_bit3, sensor_one_res_bit2, sensor_one_res_bit1, sensor_one_res_bit0}
      == $past(reg_req.wdata))
    else $error("Resistor select write not stored");
  AST_ONE_OPEN: assert property ({sensor_one_res_bit3, sensor_one_res_bit2, sensor_one_res_bit1,
      sensor_one_res_bit0} == 4'h0 |-> light_sensor_input_one_sel == 15'h0000 && light_sensor_input_one_ohm == 16'h0000)
    else $error("Sensor one not open at code zero");
  AST_TWO_OPEN: assert property ({sensor_two_res_bit3, sensor_two_res_bit2, sensor_two_res_bit1,
      sensor_two_res_bit0} == 4'h0 |-> light_sensor_input_two_sel == 15'h0000 && light_sensor_input_two_ohm == 16'h0000)
    else $error("Sensor two not open at code zero");
  AST_ONE_HOT: assert property (s_q.sel[3:0] != 4'h0 |->
      $onehot(light_sensor_input_one_sel) && light_sensor_input_one_sel[s_q.sel[3:0] - 4'h1]
      && light_sensor_input_one_ohm != 16'h0000)
    else $error("Sensor one switch pattern wrong");
  AST_TWO_HOT: assert property (s_q.sel[7:4] != 4'h0 |->
      $onehot(light_sensor_input_two_sel) && light_sensor_input_two_sel[s_q.sel[7:4] - 4'h1]
      && light_sensor_input_two_ohm != 16'h0000)
    else $error("Sensor two switch pattern wrong");
  AST_BRT_WRITE: assert property (brt_write |=> brightness_code == $past(reg_req.wdata[6:0]))
    else $error("Brightness write not stored");
  AST_BRT_READ: assert property (reg_req.rd && reg_req.addr == LED_BRIGHTNESS_ADDR |=>
      reg_rdata == {1'b0, $past(brightness_code)})
    else $error("Brightness readback wrong");
  AST_FS_MIRROR: assert property (##1 full_scale_led_current == $past(full_scale_sel))
    else $error("Full-scale select not followed");
  AST_LIN_LEVEL: assert property (led_level_valid && led_profile_linear && brightness_code == 7'h01
      && $stable(brightness_code) |-> led_level == LEVEL_LIN_ONE)
    else $error("Linear profile level wrong");
endmodule

// ===== verilog/bl_cfg_pkg.sv
// Purpose: Shared constants and types for the backlight configuration registers.
// Assumes: One 40 MHz clock, register requests come from a serial-host front end.
// Notes: Level figures are in parts per 100000 of the selected full-scale current.
package bl_cfg_pkg;

  // Register offsets
  localparam logic [7:0] SENSOR_RES_SEL_ADDR = 8'h41;
  localparam logic [7:0] LED_BRIGHTNESS_ADDR = 8'hA0;

  // Reset values
  localparam logic [7:0] SENSOR_RES_SEL_RST = 8'h00;
  localparam logic [6:0] BRIGHTNESS_RST = 7'h7F;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

  // Field positions
  localparam int SENSOR_ONE_LSB = 0;
  localparam int SENSOR_TWO_LSB = 4;
  localparam int RES_FIELD_W = 4;
  localparam int BRT_CODE_W = 7;

  // Brightness code end points
  localparam logic [6:0] BRT_CODE_OFF = 7'h00;
  localparam logic [6:0] BRT_CODE_ONE = 7'h01;
  localparam logic [6:0] BRT_CODE_FULL = 7'h7F;

  // Level scale: full scale is 100000 parts
  localparam logic [16:0] LEVEL_FULL = 17'h1_86A0;
  localparam logic [16:0] LEVEL_EXP_ONE = 17'h0_0050;
  localparam logic [16:0] LEVEL_LIN_ONE = 17'h0_0313;
  localparam logic [23:0] LIN_DIVISOR = 24'h00_007F;
  // Exponential step factor per code, Q16 (about 1.0582)
  localparam logic [16:0] EXP_STEP_Q16 = 17'h1_0EE8;
  localparam int EXP_FRAC_BITS = 8;
  localparam int EXP_STEPS_MAX = 126;

  // Resistance in ohms for codes 1..15, largest first; index 0 is open
  localparam logic [15:0] RES_OHM_TABLE [16] = '{
    16'h0000, 16'h34DB, 16'h2333, 16'h1524, 16'h08DF, 16'h079A, 16'h0717, 16'h0640,
    16'h0472, 16'h041A, 16'h03F3, 16'h03AD, 16'h02F7, 16'h02CF, 16'h02BC, 16'h029B
  };

  // Register request from the host front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // Converter sequencing, Gray along idle-step-finish
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_STEP = 2'b01,
    CV_FINISH = 2'b11
  } conv_state_e;

  // Converter state
  typedef struct packed {
    conv_state_e st;
    logic [6:0] code;
    logic lin;
    logic [6:0] cnt;
    logic [24:0] acc;
    logic [16:0] level;
  } conv_state_s;

  // Register bank state
  typedef struct packed {
    logic [7:0] sel;
    logic [6:0] led_brightness_code;
    logic [7:0] rdata;
    logic [14:0] oh_one;
    logic [14:0] oh_two;
    logic [15:0] ohm_one;
    logic [15:0] ohm_two;
    logic [2:0] fs;
    logic lin;
    logic init;
  } bank_state_s;

endpackage

// ===== verilog/brightness_level_conv.sv
// Purpose: Turns a 7-bit brightness code into a fraction of full-scale current.
// Assumes: start is a one-cycle pulse; a new start restarts any conversion.
// Notes: Exponential profile is walked one step per clock, up to 125 steps.
`timescale 1ns/1ps
module brightness_level_conv
  import bl_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [6:0] code,
  input wire logic linear,
  output logic [16:0] level,
  output logic level_valid
);

  conv_state_s s_q, s_d; // All converter state
  logic [41:0] prod; // Exponential step product
  logic [23:0] lin_num; // Linear numerator
  logic [16:0] lin_level; // Linear result
  logic [16:0] exp_level; // Exponential result, clipped

  // Arithmetic helpers
  always_comb begin
    prod = {17'h0_0000, s_q.acc} * {25'h000_0000, EXP_STEP_Q16};
    lin_num = 24'(code * LEVEL_FULL);
    lin_level = 17'(lin_num / LIN_DIVISOR);
    exp_level = (s_q.acc[24:EXP_FRAC_BITS] > LEVEL_FULL) ? LEVEL_FULL : s_q.acc[24:EXP_FRAC_BITS];
  end

  // Next-state logic
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.code = code;
      s_d.lin = linear;
      s_d.st = CV_IDLE;
      if (code == BRT_CODE_OFF) begin
        s_d.level = '0;
      end else if (code == BRT_CODE_FULL) begin
        s_d.level = LEVEL_FULL;
      end else if (linear) begin
        s_d.level = lin_level;
      end else begin
        // Seed at code one, then one step per code above it
        s_d.acc = {LEVEL_EXP_ONE, 8'h00};
        s_d.cnt = code - BRT_CODE_ONE;
        s_d.st = CV_STEP;
      end
    end else begin
      case (s_q.st)
        CV_IDLE: begin
          s_d.st = CV_IDLE;
        end
        CV_STEP: begin
          if (s_q.cnt == 7'h00) begin
            s_d.st = CV_FINISH;
          end else begin
            s_d.acc = prod[40:16];
            s_d.cnt = s_q.cnt - 7'h01;
          end
        end
        CV_FINISH: begin
          s_d.level = exp_level;
          s_d.st = CV_IDLE;
        end
        default: begin
          s_d.st = CV_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: CV_IDLE, code: 7'h00, lin: 1'b0, cnt: 7'h00, acc: 25'h000_0000, level: 17'h0_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.level;
  assign level_valid = (s_q.st == CV_IDLE) && !start;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence exp_one_start;
    start && code == BRT_CODE_ONE && !linear ##1 !start [*2];
  endsequence

  sequence lin_one_start;
    start && code == BRT_CODE_ONE && linear;
  endsequence

  AST_OFF_LEVEL: assert property (level_valid && s_q.code == BRT_CODE_OFF |-> level == 17'h0_0000)
    else $error("Code zero did not give zero level");
  AST_FULL_LEVEL: assert property (level_valid && s_q.code == BRT_CODE_FULL |-> level == LEVEL_FULL)
    else $error("Full code did not give full level");
  AST_EXP_ONE: assert property (exp_one_start |=> level == LEVEL_EXP_ONE && level_valid)
    else $error("Exponential code one level wrong");
  AST_LIN_ONE: assert property (lin_one_start |=> level == LEVEL_LIN_ONE)
    else $error("Linear code one level wrong");
  AST_EXP_BOUND: assert property (start && !linear |-> ##[1:130] level_valid)
    else $error("Exponential conversion took too long");
endmodule
